// >>> bench/ris_far_side.sv
// far side: reset pin network, supply detector and bus line
// assumes the bench steers it with level requests on clk
`timescale 1ns/100ps
module ris_far_side #(
  parameter int BIT_CYC = 8
) (
  input  wire logic clk,
  input  wire logic pin_low,
  input  wire logic power_up,
  input  wire logic bus_dominant,
  output logic      reset_pin_n,
  output logic      supply_ok,
  output logic      can_rx,
  output logic      can_bit_tick
);
  int cnt = 0;
  initial begin
    {reset_pin_n, supply_ok, can_rx, can_bit_tick} = 4'ha;
  end
  // an undriven bus reads recessive, so can_rx idles high
  always @(posedge clk) begin
    reset_pin_n  <= !pin_low;
    supply_ok    <= power_up;
    can_rx       <= !bus_dominant;
    cnt          <= (cnt == BIT_CYC - 1) ? 0 : cnt + 1;
    can_bit_tick <= (cnt == BIT_CYC - 1);
  end
endmodule

// >>> bench/ris_seq_monitor.sv
// port assertions for the reset and initialization sequencer
// assumes it is bound into ris_reset_init_seq, one clock domain
`timescale 1ns/100ps
module ris_seq_monitor
  import ris_pkg::*;
(
  input wire logic       clk,
  input wire logic       arst_n,
  input wire logic       reset_pin_n,
  input wire logic       supply_ok,
  input wire logic       tc_tick,
  input wire logic       core_reset_n,
  input wire ris_port_t  port_q,
  input wire logic [7:0] port_l_oe,
  input wire logic [7:0] port_g_oe,
  input wire logic [7:0] mem_raddr,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] can_rxtx_status_reg,
  input wire logic       can_frame_enable,
  input wire logic       tx0_drive_enable,
  input wire logic       tx1_drive_enable,
  input wire logic       tx0_oe,
  input wire logic       tx1_oe
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // five cycles cover the two sync flops and the release flop, with one to spare
  a_pin_forces_reset: assert property (
    !reset_pin_n [*5] |-> !core_reset_n) else $error("pin low, core runs");
  a_supply_drop: assert property (
    !supply_ok [*5] |-> !core_reset_n) else $error("supply low, core runs");
  a_port_images: assert property (
    !core_reset_n [*2] |-> port_q == {32'h0, PORTD_RESET})
    else $error("port image wrong in reset");
  a_hiz_no_drive: assert property (
    (port_l_oe & ~(port_q.l_cfg | port_q.l_data)) == 8'h00 &&
    (port_g_oe & ~(port_q.g_cfg | port_q.g_data)) == 8'h00)
    else $error("port driven with config clear");
  a_sp_reload: assert property (
    !core_reset_n [*2] ##0 mem_raddr == ADDR_SPTR |-> mem_rdata == SP_RESET)
    else $error("stack pointer not reloaded");
  a_status_tbe: assert property (
    !core_reset_n [*2] |-> can_rxtx_status_reg == (8'h01 << TBE_BIT))
    else $error("status image wrong in reset");
  a_tick_period: assert property (
    tc_tick |=> !tc_tick [*8] ##1 !tc_tick ##1 tc_tick)
    else $error("instruction tick not one in ten");
  a_release_on_tick: assert property (
    $rose(core_reset_n) |-> $past(tc_tick)) else $error("release off tick");
  a_tx_oe_gate: assert property (
    (!tx0_oe || (tx0_drive_enable && can_frame_enable)) &&
    (!tx1_oe || (tx1_drive_enable && can_frame_enable)))
    else $error("transmit driven while gated");
  a_frame_needs_en: assert property (
    $rose(can_frame_enable) |->
    $past(tx0_drive_enable) || $past(tx1_drive_enable))
    else $error("bus opened without enable");
endmodule

bind ris_reset_init_seq ris_seq_monitor mon (.*);

// >>> bench/testbench.sv
// self-checking bench for the reset and initialization sequencer
// assumes the far-side model drives pins and bus, checker bound itself
`timescale 1ns/100ps
module testbench
  import ris_pkg::*;
;
  logic        clk = 1'b0;
  logic        arst_n, pin_low, power_up, bus_dominant;
  logic        reset_pin_n, supply_ok, can_rx, can_bit_tick;
  logic        tx0_drive_enable, tx1_drive_enable, tx0_data, tx1_data;
  ris_mem_wr_t mem_wr;
  logic [7:0]  mem_raddr, mem_rdata, port_l_oe, port_g_oe;
  logic        mem_rhit, core_reset_n, tc_tick, can_error_active;
  logic        can_frame_enable, tx0_out, tx0_oe, tx1_out, tx1_oe;
  ris_port_t   port_q;
  logic [14:0] program_counter;
  logic [7:0]  processor_status_word, timer_serial_control_reg;
  logic [7:0]  interrupt_control_reg, wake_enable_reg, wake_edge_reg;
  logic [7:0]  wake_pending_reg, comparator_control_reg, pwm_control_reg;
  logic [7:0]  can_prescaler_reg, can_bus_timing_reg, can_tx_control_reg;
  logic [7:0]  can_tx_error_count, can_rx_error_count, can_rxtx_status_reg;
  int          fail_count = 0;
  int          comparisons = 0;
  int          n;

  ris_reset_init_seq dut (.*);
  ris_far_side far (.clk(clk), .pin_low(pin_low), .power_up(power_up),
    .bus_dominant(bus_dominant), .reset_pin_n(reset_pin_n),
    .supply_ok(supply_ok), .can_rx(can_rx), .can_bit_tick(can_bit_tick));

  always #4 clk = ~clk;

  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %0t seen %0h want %0h", $time, seen, exp);
    end
  endtask

  task automatic wrap_up();
    if (fail_count == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // sel 0 waits on core release, sel 1 on the bus gate opening
  task automatic wait_hi(input bit sel, input int lim, output int cnt);
    for (cnt = 0; (sel ? can_frame_enable : core_reset_n) !== 1'b1;
         cnt++) begin
      @(negedge clk);
      if (cnt > lim) begin
        fail_count++;
        wrap_up();
      end
    end
  endtask

  task automatic rd(input logic [7:0] a, input logic [8:0] exp);
    @(posedge clk);
    mem_raddr <= a;
    @(negedge clk);
    check({mem_rhit, mem_rdata}, exp);
  endtask

  task automatic images();
    rd(ADDR_SPTR, {1'b1, SP_RESET});
    check(port_q, {32'h0, PORTD_RESET});
    check({port_l_oe, port_g_oe}, 16'h0);
    check({program_counter, processor_status_word, timer_serial_control_reg,
      interrupt_control_reg}, 39'h0);
    check({wake_enable_reg, wake_edge_reg, wake_pending_reg}, 24'h0);
    check({comparator_control_reg, pwm_control_reg}, 16'h0);
    check({can_prescaler_reg, can_bus_timing_reg, can_tx_control_reg,
      can_tx_error_count, can_rx_error_count}, 40'h0);
    check(can_rxtx_status_reg, 8'h01 << TBE_BIT);
    check(can_error_active, 1'b1);
  endtask

  task automatic t_cold();
    @(posedge clk);
    power_up <= 1'b1;
    wait_hi(0, 3000, n);
    check(n >= 2560 && n <= 2620, 1'b1);
    images();
  endtask

  // back-to-back writes to all three pointers, then read back
  task automatic t_regs();
    logic [7:0] v [3] = '{8'h55, 8'h33, 8'haa};
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      mem_wr <= '{1'b1, ADDR_XPTR + 8'(i), v[i]};
    end
    @(posedge clk);
    mem_wr.we <= 1'b0;
    for (int i = 0; i < 3; i++)
      rd(ADDR_XPTR + 8'(i), {1'b1, v[i]});
    rd(8'hff, {1'b0, ZERO8});
    rd(8'hfb, {1'b0, ZERO8});
  endtask

  // warm reset: sp reloads, x and b survive, no power-on delay
  task automatic t_ext();
    @(posedge clk);
    pin_low <= 1'b1;
    repeat (20) @(negedge clk);
    check(core_reset_n, 1'b0);
    images();
    // a write while held in reset must be refused
    @(posedge clk);
    mem_wr <= '{1'b1, ADDR_XPTR, 8'h0f};
    @(posedge clk);
    mem_wr.we <= 1'b0;
    pin_low <= 1'b0;
    wait_hi(0, 40, n);
    rd(ADDR_XPTR, 9'h155);
    rd(ADDR_BPTR, 9'h1aa);
    rd(ADDR_SPTR, {1'b1, SP_RESET});
  endtask

  task automatic t_por();
    @(posedge clk);
    power_up <= 1'b0;
    repeat (10) @(negedge clk);
    check(core_reset_n, 1'b0);
    @(posedge clk);
    power_up <= 1'b1;
    repeat (500) @(negedge clk);
    check(core_reset_n, 1'b0);
    @(posedge clk);
    pin_low <= 1'b1;
    repeat (10) @(posedge clk);
    pin_low <= 1'b0;
    wait_hi(0, 60, n);
    check(core_reset_n, 1'b1);
    check(n <= 20, 1'b1);
  endtask

  task automatic t_can();
    @(negedge clk);
    check({can_frame_enable, tx0_oe, tx1_oe}, 3'b000);
    @(posedge clk);
    tx0_drive_enable <= 1'b1;
    repeat (40) @(posedge clk);
    bus_dominant <= 1'b1;
    repeat (16) @(posedge clk);
    bus_dominant <= 1'b0;
    repeat (72) @(negedge clk);
    check(can_frame_enable, 1'b0);
    wait_hi(1, 60, n);
    check({tx0_oe, tx1_oe, tx0_out}, 3'b100);
    @(posedge clk);
    {tx0_drive_enable, tx1_drive_enable} <= 2'b01;
    @(negedge clk);
    check({tx0_oe, tx1_oe}, 2'b01);
    @(posedge clk);
    {tx0_drive_enable, tx1_drive_enable} <= 2'b00;
    repeat (2) @(negedge clk);
    check({can_frame_enable, tx0_oe, tx1_oe}, 3'b000);
  endtask

  initial begin
    {arst_n, pin_low, power_up, bus_dominant} = 4'h0;
    {tx0_drive_enable, tx1_drive_enable, tx0_data, tx1_data} = 4'h0;
    mem_wr = '0;
    mem_raddr = ADDR_SPTR;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    t_cold();
    t_regs();
    t_ext();
    t_por();
    t_can();
    wrap_up();
  end
endmodule

// >>> rtl/ris_clk_div.sv
// instruction cycle tick generator
// assumes clk is the input clock the cycle is derived from
`timescale 1ns/100ps
module ris_clk_div
  import ris_pkg::*;
(
  input  wire logic clk,
  input  wire logic arst_n,
  output logic      tc_tick
);
  logic [DIV_W-1:0] cnt_q;
  logic [DIV_W-1:0] cnt_d;

  always_comb begin
    if (cnt_q == DIV_LAST) begin
      cnt_d = '0;
    end else begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_d;
    end
  end

  // one pulse per ten input clocks
  assign tc_tick = (cnt_q == DIV_LAST);
endmodule

// >>> rtl/ris_pkg.sv
// package for the reset and initialization sequencer
// assumes a single 125 MHz clock and an active-low asynchronous reset
package ris_pkg;
  localparam int unsigned CLK_DIV        = 10;
  localparam int unsigned DIV_W          = 4;
  localparam logic [3:0]  DIV_LAST       = 4'h9;
  localparam int unsigned POR_DELAY_TC   = 256;
  localparam int unsigned POR_W          = 9;
  localparam logic [8:0]  POR_DONE       = 9'h100;
  localparam int unsigned RECESSIVE_RUN  = 11;
  localparam logic [3:0]  REC_DONE       = 4'hb;
  localparam logic [7:0]  ADDR_XPTR      = 8'hfc;
  localparam logic [7:0]  ADDR_SPTR      = 8'hfd;
  localparam logic [7:0]  ADDR_BPTR      = 8'hfe;
  localparam logic [7:0]  SP_RESET       = 8'h2f;
  localparam logic [7:0]  ZERO8          = 8'h00;
  localparam logic [3:0]  PORTD_RESET    = 4'hf;
  localparam int unsigned TBE_BIT        = 0;

  typedef struct packed {
    logic [7:0] l_data;
    logic [7:0] l_cfg;
    logic [7:0] g_data;
    logic [7:0] g_cfg;
    logic [3:0] d_out;
  } ris_port_t;

  typedef struct packed {
    logic       we;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ris_mem_wr_t;

  typedef enum logic [2:0] {
    CAN_IDLE = 3'b001,
    CAN_SYNC = 3'b010,
    CAN_RUN  = 3'b100
  } ris_can_st_t;
endpackage

// >>> rtl/ris_reset_init_seq.sv
// reset and initialization sequencer: reset sources, power-on delay,
// reset-time register values, pointer window and bus-idle gate
// assumes reset_pin_n and supply_ok are asynchronous pins, can_rx is a pin
`timescale 1ns/100ps

module ris_reset_init_seq
  import ris_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        reset_pin_n,
  input  wire logic        supply_ok,
  input  wire logic        can_rx,
  input  wire logic        can_bit_tick,
  input  wire logic        tx0_drive_enable,
  input  wire logic        tx1_drive_enable,
  input  wire logic        tx0_data,
  input  wire logic        tx1_data,
  input  wire ris_mem_wr_t mem_wr,
  input  wire logic [7:0]  mem_raddr,
  output logic [7:0]       mem_rdata,
  output logic             mem_rhit,
  output logic             core_reset_n,
  output logic             tc_tick,
  output ris_port_t        port_q,
  output logic [7:0]       port_l_oe,
  output logic [7:0]       port_g_oe,
  output logic [14:0]      program_counter,
  output logic [7:0]       processor_status_word,
  output logic [7:0]       timer_serial_control_reg,
  output logic [7:0]       interrupt_control_reg,
  output logic [7:0]       wake_enable_reg,
  output logic [7:0]       wake_edge_reg,
  output logic [7:0]       wake_pending_reg,
  output logic [7:0]       comparator_control_reg,
  output logic [7:0]       pwm_control_reg,
  output logic [7:0]       can_prescaler_reg,
  output logic [7:0]       can_bus_timing_reg,
  output logic [7:0]       can_tx_control_reg,
  output logic [7:0]       can_tx_error_count,
  output logic [7:0]       can_rx_error_count,
  output logic [7:0]       can_rxtx_status_reg,
  output logic             can_error_active,
  output logic             can_frame_enable,
  output logic             tx0_out,
  output logic             tx0_oe,
  output logic             tx1_out,
  output logic             tx1_oe
);
  logic ext_n_s;
  logic sup_s;
  logic rx_s;

  ris_sync2 #(.INIT(1'b0)) u_sync_rst (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (reset_pin_n),
    .dout   (ext_n_s)
  );
  ris_sync2 #(.INIT(1'b0)) u_sync_sup (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (supply_ok),
    .dout   (sup_s)
  );
  ris_sync2 #(.INIT(1'b1)) u_sync_rx (
    .clk    (clk),
    .arst_n (arst_n),
    .din    (can_rx),
    .dout   (rx_s)
  );
  ris_clk_div u_div (
    .clk     (clk),
    .arst_n  (arst_n),
    .tc_tick (tc_tick)
  );

  // power-on delay and internal reset
  logic [POR_W-1:0] por_cnt_q;
  logic [POR_W-1:0] por_cnt_d;
  logic             por_done_q;
  logic             por_done_d;
  logic             run_q;
  logic             run_d;

  always_comb begin
    por_cnt_d  = por_cnt_q;
    por_done_d = por_done_q;
    run_d      = run_q;
    if (!sup_s) begin
      // supply below retention: restart the whole power-up sequence
      por_cnt_d  = '0;
      por_done_d = 1'b0;
      run_d      = 1'b0;
    end else if (!ext_n_s) begin
      // external reset, second only to supply loss, retires any pending delay
      por_cnt_d  = '0;
      por_done_d = 1'b1;
      run_d      = 1'b0;
    end else if (!por_done_q) begin
      if (tc_tick) begin
        por_cnt_d = por_cnt_q + 9'h001;
      end
      if (por_cnt_q == POR_DONE) begin
        por_done_d = 1'b1;
      end
    end else if (tc_tick) begin
      run_d = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      por_cnt_q  <= '0;
      por_done_q <= 1'b0;
      run_q      <= 1'b0;
    end else begin
      por_cnt_q  <= por_cnt_d;
      por_done_q <= por_done_d;
      run_q      <= run_d;
    end
  end

  assign core_reset_n = run_q;
  logic in_rst;
  assign in_rst = !run_q;
  logic cold;
  assign cold = !por_done_q;

  // reset-time register images; loaded while in reset, held unchanged out of reset
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      port_q                   <= '{ZERO8, ZERO8, ZERO8, ZERO8, PORTD_RESET};
      program_counter          <= '0;
      processor_status_word    <= ZERO8;
      timer_serial_control_reg <= ZERO8;
      interrupt_control_reg    <= ZERO8;
      wake_enable_reg          <= ZERO8;
      wake_edge_reg            <= ZERO8;
      wake_pending_reg         <= ZERO8;
      comparator_control_reg   <= ZERO8;
      pwm_control_reg          <= ZERO8;
      can_prescaler_reg        <= ZERO8;
      can_bus_timing_reg       <= ZERO8;
      can_tx_control_reg       <= ZERO8;
      can_tx_error_count       <= ZERO8;
      can_rx_error_count       <= ZERO8;
      can_rxtx_status_reg      <= ZERO8;
    end else if (in_rst) begin
      port_q <= '{ZERO8, ZERO8, ZERO8, ZERO8, PORTD_RESET};
      program_counter          <= '0;
      processor_status_word    <= ZERO8;
      timer_serial_control_reg <= ZERO8;
      interrupt_control_reg    <= ZERO8;
      wake_enable_reg          <= ZERO8;
      wake_edge_reg            <= ZERO8;
      wake_pending_reg         <= ZERO8;
      comparator_control_reg   <= ZERO8;
      pwm_control_reg          <= ZERO8;
      can_prescaler_reg        <= ZERO8;
      can_bus_timing_reg       <= ZERO8;
      can_tx_control_reg       <= ZERO8;
      can_tx_error_count       <= ZERO8;
      can_rx_error_count       <= ZERO8;
      can_rxtx_status_reg      <= ZERO8 | (8'h01 << TBE_BIT);
    end
  end

  // port drivers: config bit high drives the pin
  assign port_l_oe = port_q.l_cfg;
  assign port_g_oe = port_q.g_cfg;

  // pointer window; no reset branch so warm reset keeps x and b, sp is reloaded
  logic [7:0] xptr_q;
  logic [7:0] bptr_q;
  logic [7:0] sptr_q;
  logic [7:0] xptr_d;
  logic [7:0] bptr_d;
  logic [7:0] sptr_d;

  always_comb begin
    xptr_d = xptr_q;
    bptr_d = bptr_q;
    sptr_d = sptr_q;
    if (in_rst) begin
      sptr_d = SP_RESET;
    end else if (mem_wr.we) begin
      case (mem_wr.addr)
        ADDR_XPTR: xptr_d = mem_wr.wdata;
        ADDR_SPTR: sptr_d = mem_wr.wdata;
        ADDR_BPTR: bptr_d = mem_wr.wdata;
        default: xptr_d = xptr_q;
      endcase
    end
  end

  // plain flops: x and b pointers are untouched by reset
  always_ff @(posedge clk) begin
    xptr_q <= xptr_d;
    bptr_q <= bptr_d;
    sptr_q <= sptr_d;
  end

  always_comb begin
    mem_rhit  = 1'b1;
    case (mem_raddr)
      ADDR_XPTR: mem_rdata = xptr_q;
      ADDR_SPTR: mem_rdata = sptr_q;
      ADDR_BPTR: mem_rdata = bptr_q;
      default: begin
        mem_rdata = ZERO8;
        mem_rhit  = 1'b0;
      end
    endcase
  end

  // can bus-idle gate; ident and length registers live in the controller
  // and are left uninitialized on purpose
  ris_can_st_t can_st_q;
  ris_can_st_t can_st_d;
  logic [3:0]  rec_cnt_q;
  logic [3:0]  rec_cnt_d;
  logic        any_en;
  assign any_en = tx0_drive_enable | tx1_drive_enable;

  always_comb begin
    can_st_d  = can_st_q;
    rec_cnt_d = rec_cnt_q;
    if (in_rst) begin
      can_st_d  = CAN_IDLE;
      rec_cnt_d = '0;
    end else begin
      case (can_st_q)
        CAN_IDLE: begin
          rec_cnt_d = '0;
          if (any_en) begin
            can_st_d = CAN_SYNC;
          end
        end
        CAN_SYNC: begin
          if (!any_en) begin
            can_st_d  = CAN_IDLE;
            rec_cnt_d = '0;
          end else if (can_bit_tick) begin
            if (!rx_s) begin
              rec_cnt_d = '0;
            end else if (rec_cnt_q == REC_DONE - 4'h1) begin
              can_st_d  = CAN_RUN;
              rec_cnt_d = '0;
            end else begin
              rec_cnt_d = rec_cnt_q + 4'h1;
            end
          end
        end
        CAN_RUN: begin
          if (!any_en) begin
            can_st_d = CAN_IDLE;
          end
        end
        default: begin
          can_st_d  = CAN_IDLE;
          rec_cnt_d = '0;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      can_st_q  <= CAN_IDLE;
      rec_cnt_q <= '0;
    end else begin
      can_st_q  <= can_st_d;
      rec_cnt_q <= rec_cnt_d;
    end
  end

  // error-active is the only state left by reset; counters are zero
  assign can_error_active = 1'b1;
  assign can_frame_enable = (can_st_q == CAN_RUN);
  // drivers stay off while disabled and during the idle hunt
  assign tx0_oe  = tx0_drive_enable & can_frame_enable;
  assign tx1_oe  = tx1_drive_enable & can_frame_enable;
  assign tx0_out = tx0_data;
  assign tx1_out = tx1_data;

  logic unused_cold;
  assign unused_cold = cold;
endmodule

// >>> rtl/ris_sync2.sv
// two-flop level synchroniser
// assumes async input, destination on clk
`timescale 1ns/100ps
module ris_sync2
  import ris_pkg::*;
#(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk,
  input  wire logic arst_n,
  input  wire logic din,
  output logic      dout
);
  logic meta_q;
  logic sync_q;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= INIT;
      sync_q <= INIT;
    end else begin
      meta_q <= din;
      sync_q <= meta_q;
    end
  end

  assign dout = sync_q;
endmodule
